// ### bench/dcr_bank_tb.sv
// self-checking testbench of the converter register bank
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
    begin \
        tests_run++; \
        if ((got) !== (ex)) begin \
            $display("BAD %s expected %h seen %h", nm, ex, got); \
            n_fail++; \
        end \
    end
module dcr_bank_tb;
    logic                 clk;
    logic                 rst;
    logic                 sclk;
    logic                 sync_n;
    logic                 sdi;
    logic [39:0][13:0]    dac_code_q;
    logic [13:0]          group0_offset_level_q;
    logic [13:0]          group1_offset_level_q;
    logic [13:0]          group234_offset_level_q;
    logic                 power_down_q;
    logic                 thermal_en_q;
    int                   n_fail;
    int                   tests_run;
    int                   hp;

    dcr_host i_dcr_host (.clk(clk), .sclk(sclk), .sync_n(sync_n), .sdi(sdi));

    dcr_bank i_dcr_bank (
        .clk(clk), .rst(rst), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
        .dac_code_q(dac_code_q),
        .group0_offset_level_q(group0_offset_level_q),
        .group1_offset_level_q(group1_offset_level_q),
        .group234_offset_level_q(group234_offset_level_q),
        .power_down_q(power_down_q), .thermal_en_q(thermal_en_q)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [23:0] frm(logic [1:0] m, logic [5:0] a, logic [13:0] d);
        dcr_pkg::dcr_frame_s f;
        f = '{mode: m, addr: a, data: d, pad: 2'h0};
        return f;
    endfunction : frm

    // expected calibrated word, clamped to the code range
    function automatic logic [13:0] cal(int x, int g, int o);
        int r;
        r = x * (g + 1) / 16384 + o - 8192;
        if (r < 0) r = 0;
        if (r > 16383) r = 16383;
        return r[13:0];
    endfunction : cal

    // settle covers synchroniser, frame decode, calculation and converter load
    task automatic wr(logic [1:0] m, logic [5:0] a, logic [13:0] d);
        i_dcr_host.send(frm(m, a, d), 24, hp);
        repeat (10) @(negedge clk);
    endtask : wr

    task automatic t_reset;
        for (int ch = 0; ch < 40; ch++) `CHK("dac_code", dcr_pkg::INPUT_RST, dac_code_q[ch])
        `CHK("level0", dcr_pkg::LEVEL_RST, group0_offset_level_q)
        `CHK("level1", dcr_pkg::LEVEL_RST, group1_offset_level_q)
        `CHK("level2", dcr_pkg::LEVEL_RST, group234_offset_level_q)
        `CHK("pd", 1'b0, power_down_q)
        `CHK("tsd", 1'b0, thermal_en_q)
    endtask : t_reset

    task automatic t_control;
        logic [13:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 14'(i);
            wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_CTRL, v);
            `CHK("pd", v[0], power_down_q)
            `CHK("tsd", v[1], thermal_en_q)
        end
    endtask : t_control

    task automatic t_levels;
        hp = 7;
        wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_LVL0, 14'h0123);
        wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_LVL1, 14'h2ABC);
        wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_LVL2, 14'h3FFF);
        `CHK("level0", 14'h0123, group0_offset_level_q)
        `CHK("level1", 14'h2ABC, group1_offset_level_q)
        `CHK("level2", 14'h3FFF, group234_offset_level_q)
        hp = 3;
    endtask : t_levels

    task automatic t_data_a;
        wr(dcr_pkg::MODE_DATA, 6'h00, 14'h0ABC);
        wr(dcr_pkg::MODE_DATA, 6'h27, 14'h3001);
        wr(dcr_pkg::MODE_DATA, dcr_pkg::CH_LIMIT, 14'h0777);
        i_dcr_host.send(frm(dcr_pkg::MODE_DATA, 6'h01, 14'h0F0F), 12, hp);
        repeat (10) @(negedge clk);
        `CHK("ch0", 14'h0ABC, dac_code_q[0])
        `CHK("ch39", 14'h3001, dac_code_q[39])
        `CHK("ch38", dcr_pkg::INPUT_RST, dac_code_q[38])
        `CHK("ch1 short", dcr_pkg::INPUT_RST, dac_code_q[1])
    endtask : t_data_a

    task automatic t_bank_b;
        wr(dcr_pkg::MODE_DATA, 6'h08, 14'h0800);
        wr(dcr_pkg::MODE_DATA, 6'h09, 14'h0900);
        wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_CTRL, 14'h0004);
        wr(dcr_pkg::MODE_DATA, 6'h09, 14'h1234);
        wr(dcr_pkg::MODE_DATA, 6'h08, 14'h3333);
        `CHK("ch9 a", 14'h0900, dac_code_q[9])
        wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_SEL0 + 6'h01, 14'h0002);
        `CHK("ch9 b", 14'h1234, dac_code_q[9])
        `CHK("ch8 a", 14'h0800, dac_code_q[8])
        wr(dcr_pkg::MODE_GAIN, 6'h09, 14'h1FFF);
        `CHK("ch9 gain", cal(14'h1234, 14'h1FFF, 14'h2000), dac_code_q[9])
        wr(dcr_pkg::MODE_OFFS, 6'h09, 14'h3F00);
        `CHK("ch9 offs", cal(14'h1234, 14'h1FFF, 14'h3F00), dac_code_q[9])
        wr(dcr_pkg::MODE_OFFS, 6'h08, 14'h3FFF);
        wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_SEL_ALL, 14'h0001);
        `CHK("ch8 clamp", cal(14'h3333, 14'h3FFF, 14'h3FFF), dac_code_q[8])
        `CHK("ch0 b", dcr_pkg::INPUT_RST, dac_code_q[0])
        wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_SEL_ALL, 14'h0000);
        // bank b trims must leave the bank a words alone
        `CHK("ch9 a kept", 14'h0900, dac_code_q[9])
        `CHK("ch0 a", 14'h0ABC, dac_code_q[0])
        // group 4 select bit 7 steers channel 39 to its untouched second word
        wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_SEL4, 14'h0080);
        `CHK("ch39 b", dcr_pkg::INPUT_RST, dac_code_q[39])
        `CHK("ch38 a", dcr_pkg::INPUT_RST, dac_code_q[38])
        wr(dcr_pkg::MODE_SPEC, dcr_pkg::SP_CTRL, 14'h0000);
    endtask : t_bank_b

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    initial begin
        n_fail    = 0;
        tests_run = 0;
        hp        = 4;
        rst       = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_control();
        t_levels();
        t_data_a();
        t_bank_b();
        results();
    end
endmodule : dcr_bank_tb

// ### bench/dcr_host.sv
// serial host model that writes frames into the register bank
`timescale 1ns/10ps
module dcr_host (
    input  wire logic clk,
    output logic      sclk,
    output logic      sync_n,
    output logic      sdi
);
    initial begin
        sclk   = 1'b0;
        sync_n = 1'b1;
        sdi    = 1'b0;
    end

    // nbits below 24 ends the frame early; half is each sclk phase in clk cycles, 3 or more
    task automatic send(input logic [23:0] frame, input int nbits, input int half);
        @(negedge clk);
        sync_n = 1'b0;
        for (int i = 23; i > 23 - nbits; i--) begin
            sdi = frame[i];
            repeat (half) @(negedge clk);
            sclk = 1'b1;
            repeat (half) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (half) @(negedge clk);
        sync_n = 1'b1;
        // a released data line must not keep showing the last bit
        sdi = ~sdi;
        repeat (4) @(negedge clk);
    endtask : send
endmodule : dcr_host

// ### hdl/dcr_bank.sv
// register bank of the 40-channel converter, written over the serial port
`timescale 1ns/10ps
module dcr_bank (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                sclk,
    input  wire logic                sync_n,
    input  wire logic                sdi,
    output logic [39:0][13:0]        dac_code_q,
    output logic [13:0]              group0_offset_level_q,
    output logic [13:0]              group1_offset_level_q,
    output logic [13:0]              group234_offset_level_q,
    output logic                     power_down_q,
    output logic                     thermal_en_q
);
    // pin synchronisers
    logic [1:0] sclk_s_q, sync_s_q, sdi_s_q;
    logic       sclk_prev_q;
    // frame assembly
    logic [23:0] shift_q, shift_d;
    logic [4:0]  cnt_q, cnt_d;
    logic        done_q, done_d;
    logic        busy_q, busy_d;
    dcr_pkg::dcr_frame_s frm;
    // storage
    logic [13:0] in_a_q [40];
    logic [13:0] in_a_d [40];
    logic [13:0] in_b_q [40];
    logic [13:0] in_b_d [40];
    logic [13:0] gain_q [40];
    logic [13:0] gain_d [40];
    logic [13:0] offs_q [40];
    logic [13:0] offs_d [40];
    logic [13:0] cal_a_q [40];
    logic [13:0] cal_a_d [40];
    logic [13:0] cal_b_q [40];
    logic [13:0] cal_b_d [40];
    logic [7:0]  sel_q [5];
    logic [7:0]  sel_d [5];
    logic [2:0]  ctrl_q, ctrl_d;
    logic [13:0] lvl0_d, lvl1_d, lvl2_d;
    logic [39:0][13:0] dac_d;
    // recalculation request
    logic        req_q, req_d;
    logic [5:0]  req_ch_q, req_ch_d;
    logic        req_bank_q, req_bank_d;
    dcr_pkg::dcr_calc_req_s calc_req;
    logic        res_valid;
    logic [13:0] res;
    logic        sclk_rise;
    logic        chan_wr;

    assign frm       = dcr_pkg::dcr_frame_s'(shift_q);
    assign sclk_rise = sclk_s_q[1] & ~sclk_prev_q;
    assign chan_wr   = done_q && frm.mode != dcr_pkg::MODE_SPEC && frm.addr < dcr_pkg::CH_LIMIT;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_s_q    <= 2'h0;
            sync_s_q    <= 2'h3;
            sdi_s_q     <= 2'h0;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_s_q    <= {sclk_s_q[0], sclk};
            sync_s_q    <= {sync_s_q[0], sync_n};
            sdi_s_q     <= {sdi_s_q[0], sdi};
            sclk_prev_q <= sclk_s_q[1];
        end
    end

    // bits beyond the frame length are dropped until the frame line rises
    always_comb begin
        shift_d = shift_q;
        cnt_d   = cnt_q;
        busy_d  = busy_q;
        done_d  = 1'b0;
        if (sync_s_q[1]) begin
            cnt_d  = 5'h00;
            busy_d = 1'b0;
        end else if (sclk_rise && !busy_q) begin
            shift_d = {shift_q[22:0], sdi_s_q[1]};
            cnt_d   = cnt_q + 5'h01;
            if (cnt_q == dcr_pkg::FRAME_LAST) begin
                done_d = 1'b1;
                busy_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_q <= 24'h000000;
            cnt_q   <= 5'h00;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
        end
    end

    // register writes and calibrated-word capture
    always_comb begin
        in_a_d  = in_a_q;
        in_b_d  = in_b_q;
        gain_d  = gain_q;
        offs_d  = offs_q;
        cal_a_d = cal_a_q;
        cal_b_d = cal_b_q;
        sel_d   = sel_q;
        ctrl_d  = ctrl_q;
        lvl0_d  = group0_offset_level_q;
        lvl1_d  = group1_offset_level_q;
        lvl2_d  = group234_offset_level_q;
        req_d      = 1'b0;
        req_ch_d   = req_ch_q;
        req_bank_d = req_bank_q;
        if (chan_wr) begin
            unique case (frm.mode)
                dcr_pkg::MODE_DATA: begin
                    if (ctrl_q[dcr_pkg::CTRL_BANK]) begin
                        in_b_d[frm.addr] = frm.data;
                    end else begin
                        in_a_d[frm.addr] = frm.data;
                    end
                end
                dcr_pkg::MODE_GAIN: gain_d[frm.addr] = frm.data;
                dcr_pkg::MODE_OFFS: offs_d[frm.addr] = frm.data;
                default: ;
            endcase
            // trim writes recompute the bank that the bank bit names
            req_d      = 1'b1;
            req_ch_d   = frm.addr;
            req_bank_d = ctrl_q[dcr_pkg::CTRL_BANK];
        end else if (done_q && frm.mode == dcr_pkg::MODE_SPEC) begin
            if (frm.addr == dcr_pkg::SP_CTRL) begin
                ctrl_d = frm.data[2:0];
            end else if (frm.addr == dcr_pkg::SP_LVL0) begin
                lvl0_d = frm.data;
            end else if (frm.addr == dcr_pkg::SP_LVL1) begin
                lvl1_d = frm.data;
            end else if (frm.addr == dcr_pkg::SP_LVL2) begin
                lvl2_d = frm.data;
            end else if (frm.addr >= dcr_pkg::SP_SEL0 && frm.addr <= dcr_pkg::SP_SEL4) begin
                sel_d[3'(frm.addr - dcr_pkg::SP_SEL0)] = frm.data[7:0];
            end else if (frm.addr == dcr_pkg::SP_SEL_ALL) begin
                for (int g = 0; g < dcr_pkg::NUM_GRP; g++) begin
                    sel_d[g] = {8{frm.data[0]}};
                end
            end
        end
        // calibrated words have no host path, only the shared unit fills them
        if (res_valid) begin
            if (req_bank_q) begin
                cal_b_d[req_ch_q] = res;
            end else begin
                cal_a_d[req_ch_q] = res;
            end
        end
    end

    // one frame takes far longer than the one-cycle calculation, so no queue
    always_comb begin
        calc_req.word = req_bank_q ? in_b_q[req_ch_q] : in_a_q[req_ch_q];
        calc_req.gain = gain_q[req_ch_q];
        calc_req.offs = offs_q[req_ch_q];
    end

    dcr_calc i_dcr_calc (
        .clk         (clk),
        .rst         (rst),
        .req_valid   (req_q),
        .req         (calc_req),
        .res_valid_q (res_valid),
        .res_q       (res)
    );

    // channel i belongs to group i/8; its select bit picks the calibrated word
    always_comb begin
        for (int i = 0; i < dcr_pkg::NUM_CH; i++) begin
            dac_d[i] = sel_q[i / dcr_pkg::GRP_SIZE][i % dcr_pkg::GRP_SIZE]
                     ? cal_b_q[i] : cal_a_q[i];
        end
    end

    // calibrated words reset to the value the reset trims would produce
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < dcr_pkg::NUM_CH; i++) begin
                in_a_q[i]     <= dcr_pkg::INPUT_RST;
                in_b_q[i]     <= dcr_pkg::INPUT_RST;
                gain_q[i]     <= dcr_pkg::GAIN_RST;
                offs_q[i]     <= dcr_pkg::OFFS_RST;
                cal_a_q[i]    <= dcr_pkg::INPUT_RST;
                cal_b_q[i]    <= dcr_pkg::INPUT_RST;
                dac_code_q[i] <= dcr_pkg::INPUT_RST;
            end
            for (int g = 0; g < dcr_pkg::NUM_GRP; g++) begin
                sel_q[g] <= dcr_pkg::SEL_RST;
            end
            ctrl_q                  <= dcr_pkg::CTRL_RST;
            group0_offset_level_q   <= dcr_pkg::LEVEL_RST;
            group1_offset_level_q   <= dcr_pkg::LEVEL_RST;
            group234_offset_level_q <= dcr_pkg::LEVEL_RST;
            power_down_q            <= 1'b0;
            thermal_en_q            <= 1'b0;
            req_q                   <= 1'b0;
            req_ch_q                <= 6'h00;
            req_bank_q              <= 1'b0;
        end else begin
            in_a_q                  <= in_a_d;
            in_b_q                  <= in_b_d;
            gain_q                  <= gain_d;
            offs_q                  <= offs_d;
            cal_a_q                 <= cal_a_d;
            cal_b_q                 <= cal_b_d;
            dac_code_q              <= dac_d;
            sel_q                   <= sel_d;
            ctrl_q                  <= ctrl_d;
            group0_offset_level_q   <= lvl0_d;
            group1_offset_level_q   <= lvl1_d;
            group234_offset_level_q <= lvl2_d;
            power_down_q            <= ctrl_d[dcr_pkg::CTRL_PD];
            thermal_en_q            <= ctrl_d[dcr_pkg::CTRL_TSD];
            req_q                   <= req_d;
            req_ch_q                <= req_ch_d;
            req_bank_q              <= req_bank_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_group_route: assert property (
        ##1 dac_code_q[9] == ($past(sel_q[1][1]) ? $past(cal_b_q[9]) : $past(cal_a_q[9])))
        else $error("channel 9 not routed by group 1 select bit 1");
    a_bank_a_write: assert property (
        chan_wr && frm.mode == dcr_pkg::MODE_DATA && !ctrl_q[2]
        |=> in_a_q[$past(frm.addr)] == $past(frm.data))
        else $error("bank A write lost");
    a_bank_b_write: assert property (
        chan_wr && frm.mode == dcr_pkg::MODE_DATA && ctrl_q[2]
        |=> in_b_q[$past(frm.addr)] == $past(frm.data))
        else $error("bank B write lost");
    a_gain_write: assert property (
        chan_wr && frm.mode == dcr_pkg::MODE_GAIN |=> gain_q[$past(frm.addr)] == $past(frm.data))
        else $error("gain trim write lost");
    a_offs_write: assert property (
        chan_wr && frm.mode == dcr_pkg::MODE_OFFS |=> offs_q[$past(frm.addr)] == $past(frm.data))
        else $error("offset trim write lost");
    a_recalc_cal_word: assert property (
        chan_wr && !ctrl_q[2] |=> req_q ##2 cal_a_q[$past(req_ch_q, 2)] == $past(res))
        else $error("calibrated word not refreshed");
    a_ctrl_outputs: assert property (
        done_q && frm.mode == dcr_pkg::MODE_SPEC && frm.addr == dcr_pkg::SP_CTRL
        |=> power_down_q == $past(frm.data[0]) && thermal_en_q == $past(frm.data[1]))
        else $error("control bits not applied");
    a_level_two_write: assert property (
        done_q && frm.mode == dcr_pkg::MODE_SPEC && frm.addr == dcr_pkg::SP_LVL2
        |=> group234_offset_level_q == $past(frm.data))
        else $error("group 2-4 offset level not written");

    cov_frame_done: cover property (done_q);
    cov_bank_b_data: cover property (chan_wr && frm.mode == dcr_pkg::MODE_DATA && ctrl_q[2]);
    cov_select_all: cover property (done_q && frm.mode == dcr_pkg::MODE_SPEC
                                    && frm.addr == dcr_pkg::SP_SEL_ALL);
endmodule : dcr_bank

// ### hdl/dcr_calc.sv
// shared gain/offset calculation unit, one result per request
`timescale 1ns/10ps
module dcr_calc (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  req_valid,
    input  wire dcr_pkg::dcr_calc_req_s req,
    output logic                       res_valid_q,
    output logic [13:0]                res_q
);
    logic [28:0] prod;
    logic [16:0] sum;
    logic [13:0] res_d;

    // code * (gain + 1) / 2^14 + offset - midscale, clamped to the code range
    always_comb begin
        prod = 29'(req.word) * 29'({1'b0, req.gain} + 15'h0001);
        sum  = 17'(prod[28:14]) + 17'(req.offs) - dcr_pkg::MIDSCALE;
        if (sum[16]) begin
            res_d = 14'h0000;
        end else if (sum > dcr_pkg::CODE_MAX) begin
            res_d = 14'h3FFF;
        end else begin
            res_d = sum[13:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_valid_q <= 1'b0;
            res_q       <= 14'h0000;
        end else begin
            res_valid_q <= req_valid;
            res_q       <= res_d;
        end
    end

    a_calc_latency: assert property (@(posedge clk) disable iff (rst)
        req_valid |=> res_valid_q) else $error("calc result missing");
endmodule : dcr_calc

// ### hdl/dcr_pkg.sv
// constants and types for the converter channel data register bank
package dcr_pkg;
    localparam int              NUM_CH      = 40;
    localparam int              NUM_GRP     = 5;
    localparam int              GRP_SIZE    = 8;
    localparam int              DW          = 14;
    localparam int              FRAME_BITS  = 24;
    localparam logic [4:0]      FRAME_LAST  = 5'h17;

    localparam logic [13:0]     INPUT_RST   = 14'h1555;
    localparam logic [13:0]     GAIN_RST    = 14'h3FFF;
    localparam logic [13:0]     OFFS_RST    = 14'h2000;
    localparam logic [13:0]     LEVEL_RST   = 14'h1555;
    localparam logic [2:0]      CTRL_RST    = 3'h0;
    localparam logic [7:0]      SEL_RST     = 8'h00;
    localparam logic [16:0]     MIDSCALE    = 17'h02000;
    localparam logic [16:0]     CODE_MAX    = 17'h03FFF;

    localparam int              CTRL_PD     = 0;
    localparam int              CTRL_TSD    = 1;
    localparam int              CTRL_BANK   = 2;

    // frame mode field
    localparam logic [1:0]      MODE_SPEC   = 2'h0;
    localparam logic [1:0]      MODE_GAIN   = 2'h1;
    localparam logic [1:0]      MODE_OFFS   = 2'h2;
    localparam logic [1:0]      MODE_DATA   = 2'h3;

    // special-function addresses and the channel address limit
    localparam logic [5:0]      SP_CTRL     = 6'h01;
    localparam logic [5:0]      SP_LVL0     = 6'h02;
    localparam logic [5:0]      SP_LVL1     = 6'h03;
    localparam logic [5:0]      SP_LVL2     = 6'h04;
    localparam logic [5:0]      SP_SEL0     = 6'h05;
    localparam logic [5:0]      SP_SEL4     = 6'h09;
    localparam logic [5:0]      SP_SEL_ALL  = 6'h0A;
    localparam logic [5:0]      CH_LIMIT    = 6'h28;

    typedef struct packed {
        logic [1:0]  mode;
        logic [5:0]  addr;
        logic [13:0] data;
        logic [1:0]  pad;
    } dcr_frame_s;

    typedef struct packed {
        logic [13:0] word;
        logic [13:0] gain;
        logic [13:0] offs;
    } dcr_calc_req_s;
endpackage : dcr_pkg
